// [logic/ccirq_ctrl.sv]
// How it works
// - the limit code is 01 for a 100mA USB port, 11 for a 500mA port and 10 on an adapter.
// - a drop of the adapter sense moves the limit code on the third update, after two synchroniser stages.
// - a falling edge of the charger alert sets charger status bit 0 unless masked.
// - every source has one mask set for S0 and one for the sleep states.
// - mask bit 1 masks; port masks hold pin n at bit n and reset to FF, charger masks to 01.
// - an unmasked source status propagates to its sub-block bit in the first level.
// - the irq output is high while any unmasked first-level bit is set.
// - the first-level status register carries one bit per interrupting sub-block.
// - a first-level mask bit blocks both the first-level bit and the irq output.
// - first-level bits cannot be written; they fall once their source bits are cleared.
// - the irq output drops once no unmasked first-level bit remains.
// - source status bits clear on a write of 1, a 0 leaves them alone.
// - a masked source neither sets its status bit nor reaches the first level.
// - a set in the same cycle as a clear wins, the SoC must clear again.
`timescale 1ns/10ps
module ccirq_ctrl (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  // register port from the serial front end
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regWData,
  output logic      [7:0]            regRData,
  // sequencer and gpio block
  input  wire ccirq_pkg::ccirq_pwr_e powerState,
  input  wire logic [15:0]           gpioEvent,
  input  wire logic                  usbHighPower,
  // charger pins
  input  wire logic                  chargerAlertN,
  input  wire logic                  usbChargerDetectN,
  input  wire logic                  adapterSense,
  output logic [1:0]                 currentLimitCode,
  // SoC interrupt
  output logic                       irqOut
);

  logic       chgStatus_reg, chgStatus_next;
  logic [15:0] portStatus_reg, portStatus_next;
  logic       chgMaskAct_reg, chgMaskAct_next;
  logic       chgMaskSlp_reg, chgMaskSlp_next;
  logic [15:0] portMaskAct_reg, portMaskAct_next;
  logic [15:0] portMaskSlp_reg, portMaskSlp_next;
  logic [6:0] lvl1Mask_reg, lvl1Mask_next;
  logic [7:0] lvl1Status_reg, lvl1Status_next;
  logic       irq_reg, irq_next;
  logic [1:0] limit_reg, limit_next;
  logic [7:0] rdata_reg, rdata_next;

  logic [2:0] pinLevel;
  logic [2:0] pinFall;
  logic       sleepSel;
  logic       chgMaskCur;
  logic [15:0] portMaskCur;
  logic       chgPending;
  logic       portPending;

  function automatic logic wrHit(input logic we, input logic [7:0] a, input logic [7:0] t);
    wrHit = we && (a == t);
  endfunction

  ccirq_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h7)
  ) pinSync (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .pinIn ({adapterSense, usbChargerDetectN, chargerAlertN}),
    .level (pinLevel),
    .fall  (pinFall)
  );

  always_comb
  begin
    sleepSel    = (powerState != ccirq_pkg::PWR_S0);
    chgMaskCur  = sleepSel ? chgMaskSlp_reg : chgMaskAct_reg;
    portMaskCur = sleepSel ? portMaskSlp_reg : portMaskAct_reg;

    // source status: set wins over a clear in the same cycle
    chgStatus_next = chgStatus_reg;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_CHG_STATUS)
        && regWData[ccirq_pkg::CHG_EVENT_BIT])
      chgStatus_next = 1'b0;
    if (pinFall[0] && !chgMaskCur)
      chgStatus_next = 1'b1;

    portStatus_next = portStatus_reg;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_PORT0_STATUS))
      portStatus_next[7:0] = portStatus_reg[7:0] & ~regWData;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_PORT1_STATUS))
      portStatus_next[15:8] = portStatus_reg[15:8] & ~regWData;
    portStatus_next = portStatus_next | (gpioEvent & ~portMaskCur);

    // masks
    chgMaskAct_next  = chgMaskAct_reg;
    chgMaskSlp_next  = chgMaskSlp_reg;
    portMaskAct_next = portMaskAct_reg;
    portMaskSlp_next = portMaskSlp_reg;
    lvl1Mask_next    = lvl1Mask_reg;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_CHG_MASK_ACT))
      chgMaskAct_next = regWData[ccirq_pkg::CHG_EVENT_BIT];
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_CHG_MASK_SLP))
      chgMaskSlp_next = regWData[ccirq_pkg::CHG_EVENT_BIT];
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_PORT0_MASK_ACT))
      portMaskAct_next[7:0] = regWData;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_PORT1_MASK_ACT))
      portMaskAct_next[15:8] = regWData;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_PORT0_MASK_SLP))
      portMaskSlp_next[7:0] = regWData;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_PORT1_MASK_SLP))
      portMaskSlp_next[15:8] = regWData;
    if (wrHit(regWrite, regAddr, ccirq_pkg::ADDR_LVL1_MASK))
      lvl1Mask_next = regWData[ccirq_pkg::LVL1_MASK_BITS-1:0];

    // first level follows the pending sources; a write to it does nothing
    chgPending  = chgStatus_next & ~chgMaskCur;
    portPending = |(portStatus_next & ~portMaskCur);
    lvl1Status_next = ccirq_pkg::STATUS_RST;
    lvl1Status_next[ccirq_pkg::LVL1_CHRG_BIT] =
      chgPending && !lvl1Mask_next[ccirq_pkg::LVL1_CHRG_BIT];
    lvl1Status_next[ccirq_pkg::LVL1_GPIO_BIT] =
      portPending && !lvl1Mask_next[ccirq_pkg::LVL1_GPIO_BIT];
    irq_next = |lvl1Status_next;

    // adapter beats usb; a falling synchronised sense switches the code on the next clock
    if (pinLevel[2])
      limit_next = ccirq_pkg::LIMIT_ADAPTER;
    else if (!pinLevel[1])
      limit_next = ccirq_pkg::LIMIT_DCP;
    else if (usbHighPower)
      limit_next = ccirq_pkg::LIMIT_500MA;
    else
      limit_next = ccirq_pkg::LIMIT_100MA;

    // read data holds until the next read
    rdata_next = rdata_reg;
    if (regRead)
    begin
      case (regAddr)
        ccirq_pkg::ADDR_LVL1_STATUS:    rdata_next = lvl1Status_reg;
        ccirq_pkg::ADDR_CHG_STATUS:     rdata_next = {7'h00, chgStatus_reg};
        ccirq_pkg::ADDR_PORT0_STATUS:   rdata_next = portStatus_reg[7:0];
        ccirq_pkg::ADDR_PORT1_STATUS:   rdata_next = portStatus_reg[15:8];
        ccirq_pkg::ADDR_LVL1_MASK:      rdata_next = {1'b0, lvl1Mask_reg};
        ccirq_pkg::ADDR_CHG_MASK_ACT:   rdata_next = {7'h00, chgMaskAct_reg};
        ccirq_pkg::ADDR_CHG_MASK_SLP:   rdata_next = {7'h00, chgMaskSlp_reg};
        ccirq_pkg::ADDR_PORT0_MASK_ACT: rdata_next = portMaskAct_reg[7:0];
        ccirq_pkg::ADDR_PORT1_MASK_ACT: rdata_next = portMaskAct_reg[15:8];
        ccirq_pkg::ADDR_PORT0_MASK_SLP: rdata_next = portMaskSlp_reg[7:0];
        ccirq_pkg::ADDR_PORT1_MASK_SLP: rdata_next = portMaskSlp_reg[15:8];
        default:                        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      chgStatus_reg   <= 1'b0;
      portStatus_reg  <= {ccirq_pkg::STATUS_RST, ccirq_pkg::STATUS_RST};
      chgMaskAct_reg  <= ccirq_pkg::CHG_MASK_RST;
      chgMaskSlp_reg  <= ccirq_pkg::CHG_MASK_RST;
      portMaskAct_reg <= {ccirq_pkg::PORT_MASK_RST, ccirq_pkg::PORT_MASK_RST};
      portMaskSlp_reg <= {ccirq_pkg::PORT_MASK_RST, ccirq_pkg::PORT_MASK_RST};
      lvl1Mask_reg    <= ccirq_pkg::LVL1_MASK_RST;
      lvl1Status_reg  <= ccirq_pkg::STATUS_RST;
      irq_reg         <= 1'b0;
      limit_reg       <= ccirq_pkg::LIMIT_100MA;
      rdata_reg       <= 8'h00;
    end
    else if (ce)
    begin
      chgStatus_reg   <= chgStatus_next;
      portStatus_reg  <= portStatus_next;
      chgMaskAct_reg  <= chgMaskAct_next;
      chgMaskSlp_reg  <= chgMaskSlp_next;
      portMaskAct_reg <= portMaskAct_next;
      portMaskSlp_reg <= portMaskSlp_next;
      lvl1Mask_reg    <= lvl1Mask_next;
      lvl1Status_reg  <= lvl1Status_next;
      irq_reg         <= irq_next;
      limit_reg       <= limit_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign regRData         = rdata_reg;
  assign irqOut           = irq_reg;
  assign currentLimitCode = limit_reg;

endmodule // ccirq_ctrl

// [logic/ccirq_pkg.sv]
package ccirq_pkg;

  // register offsets
  localparam logic [7:0] ADDR_LVL1_STATUS    = 8'h02;
  localparam logic [7:0] ADDR_CHG_STATUS     = 8'h0A;
  localparam logic [7:0] ADDR_PORT0_STATUS   = 8'h0B;
  localparam logic [7:0] ADDR_PORT1_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_LVL1_MASK      = 8'h0E;
  localparam logic [7:0] ADDR_CHG_MASK_ACT   = 8'h17;
  localparam logic [7:0] ADDR_CHG_MASK_SLP   = 8'h18;
  localparam logic [7:0] ADDR_PORT0_MASK_ACT = 8'h19;
  localparam logic [7:0] ADDR_PORT1_MASK_ACT = 8'h1A;
  localparam logic [7:0] ADDR_PORT0_MASK_SLP = 8'h1B;
  localparam logic [7:0] ADDR_PORT1_MASK_SLP = 8'h1C;

  // reset values
  localparam logic [7:0] STATUS_RST    = 8'h00;
  localparam logic [7:0] PORT_MASK_RST = 8'hFF;
  localparam logic       CHG_MASK_RST  = 1'h1;
  localparam logic [6:0] LVL1_MASK_RST = 7'h7F;

  // field positions
  localparam int CHG_EVENT_BIT  = 0;
  localparam int LVL1_CHRG_BIT  = 4;
  localparam int LVL1_GPIO_BIT  = 5;
  localparam int LVL1_MASK_BITS = 7;

  // current limit codes
  localparam logic [1:0] LIMIT_DCP     = 2'h0;
  localparam logic [1:0] LIMIT_100MA   = 2'h1;
  localparam logic [1:0] LIMIT_500MA   = 2'h3;
  localparam logic [1:0] LIMIT_ADAPTER = 2'h2;

  // sequencer power state, gray coded along the sleep path
  typedef enum logic [1:0] {
    PWR_S0   = 2'h0,
    PWR_S0IX = 2'h1,
    PWR_S3   = 2'h3,
    PWR_S4   = 2'h2
  } ccirq_pwr_e;

endpackage

// [logic/ccirq_sync.sv]
`timescale 1ns/10ps
module ccirq_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [2:0] RESET_VAL = 3'h7
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             ce,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  // synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] last_reg;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      meta_reg   <= {WIDTH{RESET_VAL[0]}};
      stable_reg <= {WIDTH{RESET_VAL[1]}};
      last_reg   <= {WIDTH{RESET_VAL[2]}};
    end
    else if (ce)
    begin
      meta_reg   <= pinIn;
      stable_reg <= meta_reg;
      last_reg   <= stable_reg;
    end
  end

  // edge detection compares the second and third stages, never meta_reg
  assign level = stable_reg;
  assign fall  = last_reg & ~stable_reg & {WIDTH{ce}};

endmodule // ccirq_sync

// [verif/ccirq_charger_model.sv]
`timescale 1ns/10ps
module ccirq_charger_model #(
  parameter int LOW_CYC = 20000
) (
  // clock and trigger
  input  wire logic clock,
  input  wire logic fire,
  // alert pin, pulled up while idle
  output logic      chargerAlertN
);
  int unsigned lowLeft = 0;
  always_ff @(posedge clock)
  begin
    if (fire && lowLeft == 0)
      lowLeft <= LOW_CYC;
    else if (lowLeft != 0)
      lowLeft <= lowLeft - 1;
  end
  assign chargerAlertN = (lowLeft == 0);
endmodule // ccirq_charger_model

// [verif/ccirq_ctrl_monitor.sv]
`timescale 1ns/10ps
module ccirq_ctrl_monitor (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regWData,
  input wire logic [7:0]  regRData,
  // sources and charger pins
  input wire logic [15:0] gpioEvent,
  input wire logic        usbHighPower,
  input wire logic        chargerAlertN,
  input wire logic        usbChargerDetectN,
  input wire logic        adapterSense,
  input wire logic [1:0]  currentLimitCode,
  input wire logic        irqOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  function automatic logic [1:0] limitOf(logic a, logic d, logic h);
    return a ? ccirq_pkg::LIMIT_ADAPTER : (!d ? ccirq_pkg::LIMIT_DCP :
      (h ? ccirq_pkg::LIMIT_500MA : ccirq_pkg::LIMIT_100MA));
  endfunction
  chk_limit_table: assert property (
    $stable({adapterSense, usbChargerDetectN, usbHighPower})[*4]
    |-> currentLimitCode == limitOf(adapterSense, usbChargerDetectN, usbHighPower))
    else $error("limit code does not follow the pins");
  chk_limit_drop: assert property (
    $fell(adapterSense) ##1 !adapterSense[*2] |-> ##1
    currentLimitCode != ccirq_pkg::LIMIT_ADAPTER)
    else $error("limit code kept the adapter value");
  chk_irq_cause: assert property (
    $rose(irqOut) |-> $past(gpioEvent) != 16'h0000 || $past(regWrite) ||
    ($past(chargerAlertN, 4) && !$past(chargerAlertN, 3)))
    else $error("irq rose without a source");
  chk_irq_clear: assert property (
    $fell(irqOut) |-> $past(regWrite) && $past(regWData) != 8'h00)
    else $error("irq fell without a clearing write");
  chk_read_hold: assert property (
    !$past(regRead) |-> $stable(regRData))
    else $error("read data changed without a read");
  chk_unmapped_read: assert property (
    regRead && !(regAddr inside {8'h02, [8'h0A:8'h0C], 8'h0E, [8'h17:8'h1C]})
    |=> regRData == 8'h00)
    else $error("unmapped read not zero");
  chk_lvl1_spare: assert property (
    regRead && regAddr == ccirq_pkg::ADDR_LVL1_STATUS |=> (regRData & 8'hCF) == 8'h00)
    else $error("first level status has a bit without a source");
  chk_reset_values: assert property (
    $rose(nrst) |-> !irqOut && regRData == 8'h00 &&
    currentLimitCode == ccirq_pkg::LIMIT_100MA)
    else $error("outputs wrong after reset");
  cover property ($rose(irqOut));
  cover property ($fell(adapterSense));
  cover property (regRead && regAddr == 8'h05);
endmodule // ccirq_ctrl_monitor
bind ccirq_ctrl ccirq_ctrl_monitor ccirq_ctrl_monitor_inst (.clock, .nrst, .regAddr,
  .regWrite, .regRead, .regWData, .regRData, .gpioEvent, .usbHighPower,
  .chargerAlertN, .usbChargerDetectN, .adapterSense, .currentLimitCode, .irqOut);

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic        clock = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0, fire = 1'b0;
  logic        usbHighPower = 1'b0, usbChargerDetectN = 1'b1, adapterSense = 1'b0;
  logic        chargerAlertN, irqOut, pend;
  logic        ce = 1'b1;
  logic [7:0]  regAddr = 8'h00, regWData = 8'h00, regRData, st0, st1, lm, c;
  logic [7:0]  pm [4];
  logic [7:0]  rAddr [12] = '{8'h02, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h17, 8'h18, 8'h19,
                              8'h1A, 8'h1B, 8'h1C, 8'h05};
  logic [7:0]  rVal [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h01, 8'h01, 8'hFF,
                             8'hFF, 8'hFF, 8'hFF, 8'h00};
  logic [15:0] gpioEvent = 16'h0000, ev;
  logic [1:0]  currentLimitCode;
  int          n_errors = 0, compares = 0, sel;
  ccirq_pkg::ccirq_pwr_e powerState = ccirq_pkg::PWR_S0;
  ccirq_ctrl ccirq_ctrl_inst (.clock, .nrst, .ce, .regAddr, .regWrite, .regRead,
    .regWData, .regRData, .powerState, .gpioEvent, .usbHighPower, .chargerAlertN,
    .usbChargerDetectN, .adapterSense, .currentLimitCode, .irqOut);
  ccirq_charger_model ccirq_charger_model_inst (.clock, .fire, .chargerAlertN);
  function automatic logic [1:0] limitOf(logic a, logic d, logic h);
    return a ? 2'h2 : (!d ? 2'h0 : (h ? 2'h3 : 2'h1));
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    chk(regRData, exp);
  endtask
  task automatic rst();
    nrst = 1'b0;
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    for (int i = 0; i < 12; i++)
      rd(rAddr[i], rVal[i]);
  endtask
  task automatic summarize();
    $display("Counts: %0d errors in %0d compares", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    forever #5 clock = ~clock;
  end
  // the two charger alerts take about 400 us, the rest is short
  initial
  begin
    #900000;
    n_errors++;
    summarize();
  end
  initial
  begin
    void'($urandom(22));
    rst();
    for (int i = 0; i < 16; i++)
    begin
      // adapter first, so that its sense drops at i = 4 in every run
      {adapterSense, usbChargerDetectN, usbHighPower} =
        (i < 8) ? (3'(i) ^ 3'h4) : 3'($urandom);
      repeat (4) @(negedge clock);
      chk({6'h0, currentLimitCode}, {6'h0, limitOf(adapterSense, usbChargerDetectN,
        usbHighPower)});
    end
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h01);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      lm = (i == 0) ? 8'h7F : 8'h4F;
      wr(8'h0E, lm);
      for (int k = 0; k < 4; k++)
      begin
        pm[k] = 8'($urandom);
        wr(8'(8'h19 + k), pm[k]);
      end
      powerState = ccirq_pkg::ccirq_pwr_e'(2'(i));
      ev = 16'($urandom);
      gpioEvent = ev;
      @(negedge clock);
      gpioEvent = 16'h0000;
      sel = (powerState == ccirq_pkg::PWR_S0) ? 0 : 2;
      st0 = ev[7:0] & ~pm[sel];
      st1 = ev[15:8] & ~pm[sel + 1];
      pend = (|{st1, st0}) & !lm[5];
      rd(8'h0B, st0);
      rd(8'h0C, st1);
      rd(8'h02, {2'h0, pend, 5'h00});
      chk({7'h0, irqOut}, {7'h0, pend});
      c = 8'($urandom);
      wr(8'h0B, c);
      rd(8'h0B, st0 & ~c);
      wr(8'h0B, 8'hFF);
      wr(8'h0C, 8'hFF);
      rd(8'h02, 8'h00);
      chk({7'h0, irqOut}, 8'h00);
    end
    // a pulse landing on the clearing write must survive it
    wr(8'h19, 8'h00);
    powerState = ccirq_pkg::PWR_S0;
    // let an edge pass so that the strobe is not raised in the step that lowered it
    @(negedge clock);
    gpioEvent = 16'h0001;
    regAddr = 8'h0B;
    regWData = 8'h01;
    regWrite = 1'b1;
    @(negedge clock);
    gpioEvent = 16'h0000;
    regWrite = 1'b0;
    rd(8'h0B, 8'h01);
    wr(8'h0B, 8'hFF);
    // a write while the clock enable is low must be lost
    ce = 1'b0;
    wr(8'h19, 8'hA5);
    ce = 1'b1;
    rd(8'h19, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h18, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      powerState = (k != 0) ? ccirq_pkg::PWR_S3 : ccirq_pkg::PWR_S0;
      fire = 1'b1;
      @(negedge clock);
      fire = 1'b0;
      repeat (5) @(negedge clock);
      rd(8'h0A, (k != 0) ? 8'h00 : 8'h01);
      chk({7'h0, irqOut}, {7'h0, k == 0});
      wr(8'h0A, 8'h01);
      for (int t = 0; t < 30000 && !chargerAlertN; t++)
        @(negedge clock);
    end
    rst();
    summarize();
  end
endmodule // testbench
